/* logic/vfd_cmd_unit.sv */
// serial command unit: receiver, decoder, display memory, lamps, reads
// ---------------------------------------------------------------
// Summary of operation
// - strobe columns one at a time, latch returns
// - key store holds six by four bits
// - key read shifts stored bits LSB first
// - one scan pass takes one frame
// - lamp write loads bits LSB first
// - lamp bit zero lights the lamp
// - lamp byte upper four bits discarded
// - general input read shifts LSB first
// - general input read upper bits zero
// - first byte after select is command
// - select rise aborts partial byte and read-back only
// - mode command picks grid/segment configuration
// - mode change blanks display, stops scanning
// - display stays off until on command
// - same mode command has no effect
// - data command picks write or read
// - address command loads memory pointer
// - pointer 16H or above ignores data
// - memory is twenty-two eight-bit bytes
// - dimmer field selects eight grid widths
// ---------------------------------------------------------------
`timescale 1ns/1ns
`include "vfd_consts.svh"
module vfd_cmd_unit #(
    parameter int SECT_DIV = `SECT_DIV_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    input wire logic [3:0] key_return_inputs_i,
    output logic [5:0] key_strobe_lines_o,
    input wire logic [3:0] general_input_pins_i,
    output logic [3:0] lamp_outputs_o,
    output logic [3:0] disp_mode_o,
    output logic display_on_o,
    output logic grid_pwm_o,
    input wire logic [4:0] disp_rd_addr_i,
    output logic [7:0] disp_rd_data_o
);
    import vfd_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [10:0] meta_ff;
    logic [10:0] sync_ff;
    logic sclk_d_ff;
    wire sclk_s = sync_ff[0];
    wire cs_b_s = sync_ff[1];
    wire sin_s = sync_ff[2];
    wire [3:0] ret_s = sync_ff[6:3];
    wire [3:0] sw_s = sync_ff[10:7];
    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            // idle levels: shift clock high, so release shows no false edge
            meta_ff <= 11'h003;
            sync_ff <= 11'h003;
            sclk_d_ff <= 1'b1;
        end else begin
            meta_ff <= {general_input_pins_i, key_return_inputs_i,
                serial_in_i, cs_b_i, sclk_i};
            sync_ff <= meta_ff;
            sclk_d_ff <= sync_ff[0];
        end
    end

    // ---------------------------------------------------------------
    // serial receiver
    // ---------------------------------------------------------------
    logic [6:0] rx_sh_ff;
    logic [2:0] bit_cnt_ff;
    logic first_ff;
    wire rx_take = sclk_rise & ~cs_b_s;
    wire byte_done = rx_take & (bit_cnt_ff == 3'h7);
    wire [7:0] rx_byte = {sin_s, rx_sh_ff};
    rx_word_t push_word;
    logic buf_in_ready;

    assign push_word.first = first_ff;
    assign push_word.data = rx_byte;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_sh_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
            first_ff <= 1'b1;
        end else if (cs_b_s) begin
            // partial byte dropped, earlier effects kept
            bit_cnt_ff <= 3'h0;
            first_ff <= 1'b1;
        end else if (rx_take) begin
            rx_sh_ff <= rx_byte[7:1];
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_done) begin
                first_ff <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // receive buffer; decoder takes one byte per two cycles
    // ---------------------------------------------------------------
    logic pop_valid;
    logic dec_busy_ff;
    rx_word_t pop_word;
    wire pop = pop_valid & ~dec_busy_ff;

    byte_buffer #(.W(9)) u_buf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(byte_done),
        .in_ready_o(buf_in_ready),
        .in_data_i(push_word),
        .out_valid_o(pop_valid),
        .out_ready_i(~dec_busy_ff),
        .out_data_o(pop_word)
    );

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    wire [1:0] cmd_type = pop_word.data[`CMD_TYPE_MSB:`CMD_TYPE_LSB];
    wire is_cmd = pop & pop_word.first;
    wire is_dat = pop & ~pop_word.first;
    wire mode_cmd = is_cmd & (cmd_type == `CMD_MODE);
    wire data_cmd = is_cmd & (cmd_type == `CMD_DATA);
    wire ctrl_cmd = is_cmd & (cmd_type == `CMD_CTRL);
    wire addr_cmd = is_cmd & (cmd_type == `CMD_ADDR);
    wire [3:0] new_mode = pop_word.data[3:0];
    wire mode_change = mode_cmd & (new_mode != disp_mode_o);
    wire [1:0] new_xfer = pop_word.data[1:0];
    wire key_rd_cmd = data_cmd & (new_xfer == XF_KEY_RD);
    wire sw_rd_cmd = data_cmd & (new_xfer == XF_SW_RD);

    xfer_t xfer_ff;
    logic fixed_ff;
    logic [4:0] addr_ff;
    logic [3:0] mode_ff;
    logic disp_on_ff;
    logic [2:0] dim_ff;
    logic [3:0] lamp_ff;
    logic [7:0] mem [0:`MEM_DEPTH-1];
    logic [7:0] rd_data_ff;

    wire addr_ok = (addr_ff < `ADDR_LIMIT);
    wire mem_wr = is_dat & (xfer_ff == XF_DISP_WR) & addr_ok;
    wire lamp_wr = is_dat & (xfer_ff == XF_LAMP_WR);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dec_busy_ff <= 1'b0;
            xfer_ff <= XF_DISP_WR;
            fixed_ff <= 1'b0;
            addr_ff <= 5'h00;
            mode_ff <= `MODE_RST;
            disp_on_ff <= 1'b0;
            dim_ff <= `DIM_RST;
            lamp_ff <= `LAMP_RST;
        end else begin
            dec_busy_ff <= pop;
            if (mode_change) begin
                mode_ff <= new_mode;
                disp_on_ff <= 1'b0;
            end
            if (data_cmd) begin
                xfer_ff <= xfer_t'(new_xfer);
                fixed_ff <= pop_word.data[`DATA_FIX_BIT];
            end
            if (addr_cmd) begin
                addr_ff <= pop_word.data[4:0];
            end
            if (ctrl_cmd) begin
                disp_on_ff <= pop_word.data[`CTRL_ON_BIT];
                dim_ff <= pop_word.data[2:0];
            end
            if (mem_wr & ~fixed_ff) begin
                addr_ff <= addr_ff + 5'h01;
            end
            if (lamp_wr) begin
                lamp_ff <= pop_word.data[3:0];
            end
        end
    end

    // memory has no reset; contents are undefined until written
    always_ff @(posedge clk_i) begin
        if (mem_wr) begin
            mem[addr_ff] <= pop_word.data;
        end
    end

    wire rd_ok = (disp_rd_addr_i < `ADDR_LIMIT);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= rd_ok ? mem[disp_rd_addr_i] : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // read-back shifter, open-drain output
    // ---------------------------------------------------------------
    scan_if sif ();
    logic [23:0] tx_sh_ff;
    logic [4:0] tx_left_ff;
    logic out_bit_ff;
    wire [23:0] sw_word = {20'h00000, sw_s};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_sh_ff <= 24'h000000;
            tx_left_ff <= 5'h00;
            out_bit_ff <= 1'b1;
        end else if (cs_b_s) begin
            tx_left_ff <= 5'h00;
            out_bit_ff <= 1'b1;
        end else if (key_rd_cmd) begin
            tx_sh_ff <= sif.keys;
            tx_left_ff <= `KEY_RD_LEN;
        end else if (sw_rd_cmd) begin
            tx_sh_ff <= sw_word;
            tx_left_ff <= `SW_RD_LEN;
        end else if (sclk_fall) begin
            // one bit per falling edge, then released high
            out_bit_ff <= (tx_left_ff != 5'h00) ? tx_sh_ff[0] : 1'b1;
            tx_sh_ff <= {1'b0, tx_sh_ff[23:1]};
            if (tx_left_ff != 5'h00) begin
                tx_left_ff <= tx_left_ff - 5'h01;
            end
        end
    end

    assign serial_out_o = 1'b0;
    assign serial_out_oe_o = ~out_bit_ff;

    // ---------------------------------------------------------------
    // key scanner and outputs
    // ---------------------------------------------------------------
    assign sif.scan_en = disp_on_ff;
    assign sif.dimmer = dim_ff;

    key_scanner #(.SECT_DIV(SECT_DIV)) u_scan (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .key_ret_i(ret_s),
        .sif(sif)
    );

    assign key_strobe_lines_o = sif.strobe;
    assign lamp_outputs_o = lamp_ff;
    assign disp_mode_o = mode_ff;
    assign display_on_o = disp_on_ff;
    assign grid_pwm_o = sif.grid_on & disp_on_ff;
    assign disp_rd_data_o = rd_data_ff;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    mode_blank_a: assert property (mode_change |=> !disp_on_ff)
        else $error("display not blanked on mode change");
    same_mode_a: assert property (
        mode_cmd && !mode_change && !ctrl_cmd |=> $stable(disp_on_ff))
        else $error("repeated mode changed display state");
    stay_off_a: assert property (
        !disp_on_ff && !ctrl_cmd |=> !disp_on_ff)
        else $error("display came on without on command");
    lamp_low_a: assert property (
        lamp_wr |=> lamp_ff == $past(pop_word.data[3:0]))
        else $error("lamp bits not taken from low nibble");
    addr_hold_a: assert property (
        is_dat && xfer_ff == XF_DISP_WR && !addr_ok && !addr_cmd
        |=> $stable(addr_ff))
        else $error("pointer moved on ignored data");
    addr_inc_a: assert property (
        mem_wr && !fixed_ff |=> addr_ff == $past(addr_ff) + 5'h01)
        else $error("pointer did not advance after write");
    cs_abort_a: assert property (
        cs_b_s |=> bit_cnt_ff == 3'h0 && first_ff)
        else $error("receiver not reset by select rise");
    first_cmd_a: assert property (
        $fell(cs_b_s) ##1 (!cs_b_s) [*7] |-> first_ff)
        else $error("first byte flag lost before any byte");
    sw_zero_a: assert property (
        sw_rd_cmd && !cs_b_s |=> tx_sh_ff[23:4] == 20'h00000)
        else $error("general input upper bits not zero");
    do_idle_a: assert property (cs_b_s |=> !serial_out_oe_o)
        else $error("serial output driven while deselected");
    no_overrun_a: assert property (byte_done |-> buf_in_ready)
        else $error("received byte lost at full buffer");
    // decoder effects below show one cycle after the pop; the strobes clear two cycles after a mode change
    mode_keep_a: assert property (!mode_cmd |=> $stable(mode_ff))
        else $error("mode changed without a mode command");
    xfer_load_a: assert property (
        data_cmd |=> xfer_ff == $past(new_xfer))
        else $error("transfer kind not taken from data command");
    ptr_load_a: assert property (
        addr_cmd |=> addr_ff == $past(pop_word.data[4:0]))
        else $error("pointer not loaded by address command");
    dim_load_a: assert property (
        ctrl_cmd |=> dim_ff == $past(pop_word.data[2:0]))
        else $error("dimmer code not taken from control command");
    lamp_keep_a: assert property (!lamp_wr |=> $stable(lamp_ff))
        else $error("lamp bits changed without a lamp write");
    rx_first_a: assert property (byte_done |=> !first_ff)
        else $error("later bytes still marked as command");
    key_len_a: assert property (
        key_rd_cmd && !cs_b_s |=> tx_left_ff == `KEY_RD_LEN)
        else $error("key read length not loaded");
    scan_halt_a: assert property (
        mode_change |-> ##2 key_strobe_lines_o == 6'h00)
        else $error("strobes still running after mode change");
    out_free_a: assert property (
        sclk_fall && !cs_b_s && tx_left_ff == 5'h00
        && !key_rd_cmd && !sw_rd_cmd |=> !serial_out_oe_o)
        else $error("line held after last read bit");

    cover_mode_c: cover property (mode_change);
    cover_key_rd_c: cover property (key_rd_cmd);
    cover_lamp_c: cover property (lamp_wr);
endmodule : vfd_cmd_unit

/* logic/vfd_consts.svh */
// timing counts, field positions and reset values of the command unit
`ifndef VFD_CONSTS_SVH
`define VFD_CONSTS_SVH
`define KEY_COLS 6
`define KEY_ROWS 4
`define KEY_BITS 24
`define MEM_DEPTH 22
`define ADDR_LIMIT 5'h16
`define SECT_PER_SLOT 16
`define SECT_DIV_DEF 64
`define LAMP_RST 4'hF
`define MODE_RST 4'h0
`define DIM_RST 3'h0
`define CMD_TYPE_MSB 7
`define CMD_TYPE_LSB 6
`define CMD_MODE 2'h0
`define CMD_DATA 2'h1
`define CMD_CTRL 2'h2
`define CMD_ADDR 2'h3
`define DATA_FIX_BIT 2
`define CTRL_ON_BIT 3
`define KEY_RD_LEN 5'h18
`define SW_RD_LEN 5'h08
`endif

/* logic/vfd_pkg.sv */
// types and helper functions shared by the command unit files
package vfd_pkg;
    typedef enum logic [1:0] {
        XF_DISP_WR,
        XF_LAMP_WR,
        XF_KEY_RD,
        XF_SW_RD
    } xfer_t;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } rx_word_t;

    // lit sections per strobe slot for each dimmer code
    function automatic logic [4:0] dim_width(input logic [2:0] code);
        unique case (code)
            3'h0: dim_width = 5'h01;
            3'h1: dim_width = 5'h02;
            3'h2: dim_width = 5'h04;
            3'h3: dim_width = 5'h0A;
            3'h4: dim_width = 5'h0B;
            3'h5: dim_width = 5'h0C;
            3'h6: dim_width = 5'h0D;
            3'h7: dim_width = 5'h0E;
        endcase
    endfunction : dim_width
endpackage : vfd_pkg

/* logic/scan_if.sv */
// link between the command core and the key scanner
`timescale 1ns/1ns
interface scan_if;
    logic scan_en;
    logic [2:0] dimmer;
    logic [5:0] strobe;
    logic [23:0] keys;
    logic grid_on;
    logic frame_done;
    modport ctrl(output scan_en, dimmer,
        input strobe, keys, grid_on, frame_done);
    modport scan(input scan_en, dimmer,
        output strobe, keys, grid_on, frame_done);
endinterface : scan_if

/* logic/byte_buffer.sv */
// two-entry valid/ready buffer for received bytes
`timescale 1ns/1ns
module byte_buffer #(
    parameter int W = 9
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] ent_ff [0:1];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] cnt_ff;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = ent_ff[rd_ptr_ff];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
            ent_ff[0] <= '0;
            ent_ff[1] <= '0;
        end else begin
            if (push) begin
                ent_ff[wr_ptr_ff] <= in_data_i;
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    buf_no_over_a: assert property (cnt_ff <= 2'h2)
        else $error("buffer count above two");
    cover_buf_full_c: cover property (cnt_ff == 2'h2);
endmodule : byte_buffer

/* logic/key_scanner.sv */
// six-strobe key scanner with grid dimming window
`timescale 1ns/1ns
`include "vfd_consts.svh"
module key_scanner #(
    parameter int SECT_DIV = `SECT_DIV_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] key_ret_i,
    scan_if.scan sif
);
    import vfd_pkg::*;
    logic [15:0] div_ff;
    logic [3:0] sect_ff;
    logic [2:0] col_ff;
    logic [5:0] strobe_ff;
    logic [23:0] keys_ff;
    logic grid_ff;
    logic done_ff;
    wire tick = (div_ff == 16'(SECT_DIV - 1));
    wire slot_end = tick & (sect_ff == 4'(`SECT_PER_SLOT - 1));
    wire last_col = (col_ff == 3'(`KEY_COLS - 1));
    wire lit = ({1'b0, sect_ff} < dim_width(sif.dimmer));

    assign sif.strobe = strobe_ff;
    assign sif.keys = keys_ff;
    assign sif.grid_on = grid_ff;
    assign sif.frame_done = done_ff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_ff <= 16'h0000;
            sect_ff <= 4'h0;
            col_ff <= 3'h0;
            strobe_ff <= 6'h00;
            keys_ff <= 24'h000000;
            grid_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (!sif.scan_en) begin
            // scanning halts; stored keys stay readable
            div_ff <= 16'h0000;
            sect_ff <= 4'h0;
            col_ff <= 3'h0;
            strobe_ff <= 6'h00;
            grid_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
            strobe_ff <= 6'(6'h01 << col_ff);
            grid_ff <= lit;
            done_ff <= slot_end & last_col;
            if (tick) begin
                sect_ff <= sect_ff + 4'h1;
            end
            if (slot_end) begin
                // sample at slot end so the returns have settled
                keys_ff[col_ff*4 +: 4] <= key_ret_i;
                col_ff <= last_col ? 3'h0 : col_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    strobe_onehot_a: assert property ($onehot0(strobe_ff))
        else $error("more than one strobe active");
    scan_stop_a: assert property (
        !sif.scan_en |=> strobe_ff == 6'h00)
        else $error("strobe active while scanning halted");
    frame_col_a: assert property (done_ff |-> col_ff == 3'h0)
        else $error("frame ended off column zero");
    cover_frame_c: cover property (done_ff);
endmodule : key_scanner

/* testbench/host_model.sv */
// host side model: frames bytes on the serial link and reads replies
`timescale 1ns/1ns
module host_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic sclk_o,
    output logic cs_b_o,
    output logic sin_o
);
    // the shift clock idles high and stands still between frames
    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sin_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic start();
        tick(1);
        cs_b_o <= 1'b0;
        tick(8);
    endtask : start

    // data changes on the fall so it is settled well before the rise
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sclk_o <= 1'b0;
            sin_o <= b[i];
            tick(8);
            sclk_o <= 1'b1;
            tick(8);
        end
    endtask : send

    // released data is scrambled so a stale bit cannot pass for a good one
    task automatic stop();
        cs_b_o <= 1'b1;
        sin_o <= ~sin_o;
        tick(16);
    endtask : stop

    task automatic get(input int n, output logic [23:0] v);
        v = 24'h000000;
        tick(100);
        for (int i = 0; i < n; i++) begin
            sclk_o <= 1'b0;
            tick(8);
            sclk_o <= 1'b1;
            v[i] = line_i;
            tick(8);
        end
    endtask : get
endmodule : host_model

/* testbench/test_vfd_keyscan_serial_command_unit.sv */
// self-checking bench for the serial command unit against a host model
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        n_compared++; \
        if ((got) !== (ex)) begin \
            err_count++; \
            $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module test_vfd_keyscan_serial_command_unit;
    localparam int SD = 2;
    localparam int FRAME = 6 * 16 * SD;
    // ---------------------------------------------------------------
    // harness
    // ---------------------------------------------------------------
    logic clk_i;
    logic rst_b_i;
    logic sclk, cs_b, sin, oe, sout, on, pwm;
    logic [3:0] kret, sw, lamps, mode;
    logic [5:0] strb;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic [23:0] keymat, v;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed;
    int q[$];
    int mem_m[22];
    int lamp_m = 15;
    int mode_m = 0;
    int on_m = 0;
    int xf_m = 0;
    int fix_m = 0;
    int ptr_m = 0;
    int wtab[8] = '{1, 2, 4, 10, 11, 12, 13, 14};
    // open-drain reply line with its pull-up
    wire line = oe ? sout : 1'b1;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    vfd_cmd_unit #(.SECT_DIV(SD)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .sclk_i(sclk), .cs_b_i(cs_b), .serial_in_i(sin),
        .serial_out_o(sout), .serial_out_oe_o(oe),
        .key_return_inputs_i(kret), .key_strobe_lines_o(strb),
        .general_input_pins_i(sw), .lamp_outputs_o(lamps),
        .disp_mode_o(mode), .display_on_o(on), .grid_pwm_o(pwm),
        .disp_rd_addr_i(rd_addr), .disp_rd_data_o(rd_data));
    host_model host (.clk_i(clk_i), .line_i(line), .sclk_o(sclk),
        .cs_b_o(cs_b), .sin_o(sin));

    // key matrix: the strobed column drives its four returns
    always @(posedge clk_i) begin
        kret <= 4'h0;
        for (int c = 0; c < 6; c++) begin
            if (strb[c] === 1'b1) begin
                kret <= keymat[c*4 +: 4];
            end
        end
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // reference model: first byte is the command, the rest its data
    task automatic model(input int nlast);
        int c;
        c = q[0];
        if (nlast < 8) void'(q.pop_back());
        case (c >> 6)
            0: if ((c & 15) != mode_m) begin
                mode_m = c & 15;
                on_m = 0;
            end
            1: begin
                xf_m = c & 3;
                fix_m = (c >> 2) & 1;
            end
            2: on_m = (c >> 3) & 1;
            default: ptr_m = c & 31;
        endcase
        for (int i = 1; i < q.size(); i++) begin
            if ((c >> 6) == 1 && xf_m == 1) lamp_m = q[i] & 15;
            if ((c >> 6) == 3 && xf_m == 0 && ptr_m < 22) begin
                mem_m[ptr_m] = q[i];
                ptr_m += 1 - fix_m;
            end
        end
    endtask : model

    task automatic frame(input int nlast);
        host.start();
        foreach (q[i]) host.send(8'(q[i]), (i == q.size() - 1) ? nlast : 8);
        host.stop();
        model(nlast);
    endtask : frame

    task automatic rd(input int cmd, input int n);
        q = '{cmd};
        host.start();
        host.send(8'(cmd), 8);
        host.get(n, v);
        host.stop();
        model(8);
        `CHK("released", 1'b0, oe)
    endtask : rd

    task automatic check_all();
        #1;
        `CHK("lamps", lamp_m, lamps)
        `CHK("display on", on_m, on)
        `CHK("mode", mode_m, mode)
        if (on_m == 0) `CHK("strobes", 6'h00, strb)
        for (int a = 0; a < 22; a++) begin
            if (mem_m[a] >= 0) begin
                @(posedge clk_i);
                rd_addr <= 5'(a);
                repeat (2) @(posedge clk_i);
                #1;
                `CHK("memory", mem_m[a], rd_data)
            end
        end
    endtask : check_all

    task automatic meas(input int d);
        int pw;
        int bad;
        logic s_prev;
        pw = 0;
        bad = 0;
        s_prev = 1'b0;
        repeat (FRAME) @(posedge clk_i);
        #1;
        for (int i = 0; i < 400 && strb[0] === 1'b1; i++) @(posedge clk_i);
        #1;
        for (int i = 0; i < 400 && strb[0] !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        for (int i = 0; i < FRAME; i++) begin
            @(posedge clk_i);
            #1;
            pw += (pwm === 1'b1);
            bad += ($countones(strb) > 1);
            if (i == FRAME - 2) s_prev = strb[0];
        end
        `CHK("frame", 2'b01, {s_prev, strb[0]})
        `CHK("grid width", 6 * wtab[d] * SD, pw)
        `CHK("one strobe", 0, bad)
    endtask : meas

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        seed = 54500;
        rst_b_i = 1'b0;
        kret = 4'h0;
        sw = 4'h0;
        rd_addr = 5'h00;
        keymat = 24'h000000;
        foreach (mem_m[a]) mem_m[a] = -1;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        check_all();
        $display("reset test done");
        q = '{8'h01};
        frame(8);
        q = '{8'h40};
        frame(8);
        q = '{8'hC0};
        repeat (22) q.push_back($random(seed) & 8'hFF);
        frame(8);
        q = '{8'h8F};
        frame(8);
        // run past the top of memory with an incrementing pointer
        q = '{8'hD3};
        repeat (5) q.push_back($random(seed) & 8'hFF);
        frame(8);
        q = '{8'h44};
        frame(8);
        q = '{8'hC5};
        repeat (2) q.push_back($random(seed) & 8'hFF);
        frame(8);
        q = '{8'hD6};
        q.push_back($random(seed) & 8'hFF);
        frame(8);
        check_all();
        $display("memory write test done");
        q = '{8'h40};
        frame(8);
        q = '{8'hC2};
        q.push_back($random(seed) & 8'hFF);
        frame(3);
        repeat (3) begin
            q = '{8'h41};
            repeat (2) q.push_back($random(seed) & 8'hFF);
            frame(5);
            check_all();
        end
        $display("lamp and abort test done");
        for (int d = 0; d < 8; d++) begin
            q = '{8'h88 | d};
            frame(8);
            meas(d);
        end
        $display("dimmer and scan test done");
        repeat (2) begin
            keymat = 24'($random(seed));
            repeat (3 * FRAME) @(posedge clk_i);
            rd(8'h42, 24);
            `CHK("keys", keymat, v)
        end
        repeat (2) begin
            sw <= 4'($random(seed));
            repeat (8) @(posedge clk_i);
            rd(8'h43, 8);
            `CHK("general inputs", {20'h00000, sw}, v)
        end
        $display("read test done");
        q = '{8'h03};
        frame(8);
        check_all();
        q = '{8'h8A};
        frame(8);
        check_all();
        q = '{8'h03};
        frame(8);
        check_all();
        q = '{8'h85};
        frame(8);
        check_all();
        $display("mode test done");
        finish_test();
    end
endmodule : test_vfd_keyscan_serial_command_unit
